//--- hdl/ddr_shell_pkg.sv
package ddr_shell_pkg;
  // memory families
  typedef enum logic [1:0] {MEM_LPDDR, MEM_DDR2, MEM_DDR3} mem_family_t;
  // fabric interface options
  typedef enum logic [1:0] {FIC_AXI64, FIC_AHB1, FIC_AHB2} fic_mode_t;
  // data width codes
  localparam logic [1:0] DW_32 = 2'h0;
  localparam logic [1:0] DW_16 = 2'h1;
  localparam logic [1:0] DW_8 = 2'h2;
  localparam int DW32_BITS = 32;
  localparam int DW16_BITS = 16;
  localparam int DW8_BITS = 8;
  // memory clock range, MHz
  localparam int MEM_CLK_MIN_MHZ = 20;
  localparam int MEM_CLK_MAX_MHZ = 333;
  localparam int DDR_EDGES = 2;
  localparam int AXI_W = 64;
  localparam int AHB_W = 32;
  localparam logic [7:0] DIV_ONE = 8'h01;
  localparam logic [7:0] DIV_ZERO = 8'h00;
  // one fabric request word
  typedef struct packed {
    logic wr;
    logic [31:0] addr;
    logic [63:0] data;
  } fab_req_t;
  localparam int REQ_W = $bits(fab_req_t);
endpackage

//--- hdl/req_fifo.sv
module req_fifo
  import ddr_shell_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic [WIDTH-1:0] wdata_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [WIDTH-1:0] rdata_out,
  output logic rvalid_out,
  input wire logic rready_in
);
  localparam int AW = $clog2(DEPTH);
  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("depth must be a power of two");
  end
  // storage array
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;
  logic full;
  logic empty;
  logic push;
  logic pop;
  assign full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  assign empty = (wp_r == rp_r);
  assign wready_out = !full;
  assign rvalid_out = !empty;
  assign rdata_out = mem[rp_r[AW-1:0]];
  assign push = ce_in && wvalid_in && !full;
  assign pop = ce_in && rready_in && !empty;
  // write side
  always_ff @(posedge clk_sys_in)
  begin
    if (push)
      mem[wp_r[AW-1:0]] <= wdata_in;
  end
  // pointers
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wp_r <= '0;
      rp_r <= '0;
    end
    else
    begin
      if (push)
        wp_r <= wp_r + 1'b1;
      if (pop)
        rp_r <= rp_r + 1'b1;
    end
  end
endmodule

//--- hdl/fabric_ddr_controller_shell.sv
// Notes on behaviour
// R1: memory family LPDDR, DDR2 or DDR3 selectable
// R2: memory data width 32, 16 or 8
// R3: memory clock 20 to 333 MHz
// R4: fabric transactions become memory transactions
// R5: AXI option: one 64-bit initiator port
// R6: single AHB option: one 32-bit port
// R7: dual AHB option: two 32-bit ports
// R8: fabric clock is controller clock over divisor; with a divisor of one fabric_if_clk_out stays low
// R9: attached bus runs at fabric clock
// R10: keep reset until base clock stable
// R11: optional lock input from clock conditioner
// R12: interrupts present only when enabled
// R13: bus error raises fabric error interrupt
// R14: calibration done raises calibration interrupt; the code raises it only for a done while a cal_start_in is outstanding
// R15: internal pll lock raises lock interrupt
// R16: lock loss after lock raises interrupt
// R17: ecc single or double error interrupt
// R18: data rate twice memory clock
// R19: missing lock holds internal reset
module fabric_ddr_controller_shell
  import ddr_shell_pkg::*;
#(
  parameter bit USE_LOCK = 1'b1,
  parameter bit IRQ_EN = 1'b1,
  parameter bit ECC_EN = 1'b1,
  parameter int FIFO_DEPTH = 16
)
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic ext_pll_locked_in,
  input wire mem_family_t mem_family_in,
  input wire logic [1:0] data_width_in,
  input wire logic [8:0] mem_clk_mhz_in,
  input wire fic_mode_t fic_mode_in,
  input wire logic [7:0] clk_div_in,
  input wire fab_req_t axi_req_in,
  input wire logic axi_valid_in,
  output logic axi_ready_out,
  input wire fab_req_t ahb0_req_in,
  input wire logic ahb0_valid_in,
  output logic ahb0_ready_out,
  input wire fab_req_t ahb1_req_in,
  input wire logic ahb1_valid_in,
  output logic ahb1_ready_out,
  output fab_req_t mem_req_out,
  output logic mem_valid_out,
  input wire logic mem_ready_in,
  input wire logic bus_err_in,
  input wire logic cal_start_in,
  input wire logic cal_done_in,
  input wire logic pll_lock_in,
  input wire logic ecc_single_in,
  input wire logic ecc_double_in,
  output logic fabric_if_clk_out,
  output logic [9:0] line_rate_mbps_out,
  output logic [5:0] phy_width_out,
  output logic cfg_err_out,
  output logic bus_err_irq_out,
  output logic cal_irq_out,
  output logic pll_locked_irq_out,
  output logic pll_unlocked_irq_out,
  output logic ecc_irq_out
);
  initial
  begin
    if (FIFO_DEPTH != 16)
      $error("fifo depth must be 16");
  end

  // ********************************************************
  // internal reset and configuration
  // ********************************************************
  logic run_r; // internal reset released
  logic [7:0] div_cnt_r; // fabric clock divider
  logic arb_r; // dual ahb turn
  logic cal_busy_r; // recalibration outstanding
  logic pll_seen_r; // pll has locked once
  logic pll_d_r; // previous pll lock
  logic cfg_bad; // unsupported setting
  logic div_wrap;
  logic fab_tick; // one cycle per fabric period

  // held in reset while lock missing; reset cannot be deasserted early
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      run_r <= 1'b0;
    else if (ce_in)
      run_r <= USE_LOCK ? ext_pll_locked_in : 1'b1; // R19 R11 R10
  end

  // configuration checks
  always_comb
  begin
    cfg_bad = 1'b0;
    if (mem_family_in != MEM_LPDDR && mem_family_in != MEM_DDR2 &&
        mem_family_in != MEM_DDR3)
      cfg_bad = 1'b1; // R1
    if (data_width_in != DW_32 && data_width_in != DW_16 &&
        data_width_in != DW_8)
      cfg_bad = 1'b1; // R2
    if (mem_clk_mhz_in < 9'(MEM_CLK_MIN_MHZ) ||
        mem_clk_mhz_in > 9'(MEM_CLK_MAX_MHZ))
      cfg_bad = 1'b1; // R3
    if (clk_div_in == DIV_ZERO)
      cfg_bad = 1'b1; // R8
  end

  // registered config views
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cfg_err_out <= 1'b0;
      line_rate_mbps_out <= '0;
      phy_width_out <= '0;
    end
    else if (ce_in)
    begin
      cfg_err_out <= cfg_bad;
      line_rate_mbps_out <= 10'(DDR_EDGES) * {1'b0, mem_clk_mhz_in}; // R18
      case (data_width_in)
        DW_16: phy_width_out <= 6'(DW16_BITS); // R2
        DW_8: phy_width_out <= 6'(DW8_BITS);
        default: phy_width_out <= 6'(DW32_BITS);
      endcase
    end
  end

  // ********************************************************
  // fabric interface clock divider
  // ********************************************************
  assign div_wrap = (div_cnt_r >= clk_div_in - DIV_ONE);
  assign fab_tick = run_r && div_wrap;

  // square-ish clock: high for the first half of the count
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      div_cnt_r <= '0;
      fabric_if_clk_out <= 1'b0;
    end
    else if (ce_in)
    begin
      if (!run_r || div_wrap)
        div_cnt_r <= '0; // R8
      else
        div_cnt_r <= div_cnt_r + 8'h01;
      fabric_if_clk_out <= run_r && (div_cnt_r < (clk_div_in >> 1)); // R8
    end
  end

  // ********************************************************
  // target ports into request fifo
  // ********************************************************
  fab_req_t sel_req;
  logic sel_valid;
  logic fifo_wready;
  logic sel_axi;
  logic sel_a0;
  logic sel_a1;

  // port selection; attached bus steps on fabric ticks only
  always_comb
  begin
    sel_axi = 1'b0;
    sel_a0 = 1'b0;
    sel_a1 = 1'b0;
    case (fic_mode_in)
      FIC_AXI64: sel_axi = axi_valid_in; // R5
      FIC_AHB1: sel_a0 = ahb0_valid_in; // R6
      FIC_AHB2:
      begin
        // alternate priority between the two initiators
        sel_a0 = ahb0_valid_in && (!arb_r || !ahb1_valid_in); // R7
        sel_a1 = ahb1_valid_in && !sel_a0; // R7
      end
      default: ;
    endcase
    // no take while an accept pulse stands: the initiator only drops
    // valid on seeing ready, so a divisor of one would take twice
    sel_valid = fab_tick && !cfg_err_out && (sel_axi || sel_a0 || sel_a1)
                && !(axi_ready_out || ahb0_ready_out || ahb1_ready_out);
    sel_req = sel_axi ? axi_req_in : (sel_a1 ? ahb1_req_in : ahb0_req_in);
    if (!sel_axi)
      sel_req.data[AXI_W-1:AHB_W] = '0; // R6 R7
  end

  // acceptance strobes, one system clock cycle each; bus at fabric rate R9
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      axi_ready_out <= 1'b0;
      ahb0_ready_out <= 1'b0;
      ahb1_ready_out <= 1'b0;
      arb_r <= 1'b0;
    end
    else if (ce_in)
    begin
      axi_ready_out <= sel_valid && sel_axi && fifo_wready; // R5
      ahb0_ready_out <= sel_valid && sel_a0 && fifo_wready; // R6
      ahb1_ready_out <= sel_valid && sel_a1 && fifo_wready; // R7
      if (sel_valid && fifo_wready && fic_mode_in == FIC_AHB2)
        arb_r <= sel_a0;
    end
  end

  // ********************************************************
  // request fifo toward memory side
  // ********************************************************
  fab_req_t fifo_rdata;
  logic fifo_rvalid;
  logic fifo_pop;
  // pop only when output stage empty or draining
  assign fifo_pop = run_r && (!mem_valid_out || mem_ready_in);

  req_fifo #(
    .WIDTH(REQ_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .wdata_in(sel_req),
    .wvalid_in(sel_valid),
    .wready_out(fifo_wready),
    .rdata_out(fifo_rdata),
    .rvalid_out(fifo_rvalid),
    .rready_in(fifo_pop)
  );

  // memory transaction stage
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mem_valid_out <= 1'b0;
      mem_req_out <= '0;
    end
    else if (ce_in)
    begin
      if (!run_r)
        mem_valid_out <= 1'b0; // R19
      else if (fifo_pop)
      begin
        mem_valid_out <= fifo_rvalid; // R4
        if (fifo_rvalid)
          mem_req_out <= fifo_rdata; // R4
      end
    end
  end

  // ********************************************************
  // interrupt pulses
  // ********************************************************
  // outputs stay low when interrupts are not configured
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      bus_err_irq_out <= 1'b0;
      cal_irq_out <= 1'b0;
      pll_locked_irq_out <= 1'b0;
      pll_unlocked_irq_out <= 1'b0;
      ecc_irq_out <= 1'b0;
      cal_busy_r <= 1'b0;
      pll_seen_r <= 1'b0;
      pll_d_r <= 1'b0;
    end
    else if (ce_in)
    begin
      pll_d_r <= pll_lock_in;
      if (pll_lock_in)
        pll_seen_r <= 1'b1;
      // done wins over a new start in the same cycle
      if (cal_done_in)
        cal_busy_r <= 1'b0;
      else if (cal_start_in)
        cal_busy_r <= 1'b1;
      bus_err_irq_out <= IRQ_EN && bus_err_in; // R12 R13
      cal_irq_out <= IRQ_EN && cal_busy_r && cal_done_in; // R12 R14
      pll_locked_irq_out <= IRQ_EN && pll_lock_in && !pll_d_r; // R15
      pll_unlocked_irq_out <= IRQ_EN && pll_seen_r && pll_d_r &&
                              !pll_lock_in; // R16
      ecc_irq_out <= IRQ_EN && ECC_EN &&
                     (ecc_single_in || ecc_double_in); // R17
    end
  end

  // ********************************************************
  // checks
  // ********************************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  a_lock_holds_reset: assert property (USE_LOCK && ce_in &&
    !ext_pll_locked_in |=> !run_r) else $error("run without lock"); // R19
  a_no_mem_in_reset: assert property (!run_r |=> ce_in |-> !mem_valid_out)
    else $error("memory request in reset"); // R19
  a_rate_double: assert property (ce_in |=> line_rate_mbps_out ==
    10'(DDR_EDGES) * {1'b0, $past(mem_clk_mhz_in)})
    else $error("line rate wrong"); // R18
  a_bus_err_irq: assert property (ce_in && bus_err_in && IRQ_EN
    |=> bus_err_irq_out) else $error("bus error lost"); // R13
  a_unlock_needs_lock: assert property (pll_unlocked_irq_out
    |-> pll_seen_r) else $error("unlock before lock"); // R16
  a_lock_edge_irq: assert property (ce_in && IRQ_EN && pll_lock_in &&
    !pll_d_r |=> pll_locked_irq_out) else $error("lock missed"); // R15
  a_ecc_irq: assert property (ce_in && IRQ_EN && ECC_EN && ecc_double_in
    |=> ecc_irq_out) else $error("ecc missed"); // R17
  a_cal_irq: assert property (ce_in && cal_busy_r && cal_done_in &&
    IRQ_EN |=> cal_irq_out && !cal_busy_r) else $error("cal lost"); // R14
  a_ready_one_port: assert property ($onehot0({axi_ready_out,
    ahb0_ready_out, ahb1_ready_out})) else $error("two grants"); // R7
endmodule

//--- sim/fab_initiator_model.sv
// ************************************************
// single fabric initiator, holds request until accepted
// ************************************************
module fab_initiator_model
  import ddr_shell_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic send_in,
  input wire fab_req_t word_in,
  output logic valid_out,
  output fab_req_t req_out,
  input wire logic ready_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // one request in flight; same clock as the target port
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      valid_out <= 1'b0;
      req_out <= '0;
    end
    else if (send_in)
    begin
      // whole 64-bit word in one beat
      valid_out <= 1'b1;
      req_out <= word_in;
    end
    else if (ready_in)
    begin
      // released: show inverse so stale data never looks valid
      valid_out <= 1'b0;
      req_out <= ~req_out;
    end
  end
endmodule

//--- sim/fabric_ddr_controller_shell_tb.sv
// ************************************************
// bench for the fabric ddr controller shell
// ************************************************
module fabric_ddr_controller_shell_tb
  import ddr_shell_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in = 1'b0, rst_n_in = 1'b0, lock_in = 1'b1;
  mem_family_t fam_in = MEM_DDR2;
  fic_mode_t mode_in = FIC_AXI64;
  logic [1:0] dw_in = DW_32;
  logic [8:0] mhz_in = 9'h064;
  logic [7:0] div_in = 8'h02;
  logic mrdy_in = 1'b0, send = 1'b0;
  logic berr = 1'b0, cs = 1'b0, cd = 1'b0, pl = 1'b0, es = 1'b0, ed = 1'b0;
  fab_req_t word = '0, mreq, areq;
  logic avalid, ardy, mvalid, fclk, cerr;
  logic [9:0] rate;
  logic [5:0] wid;
  wire logic [4:0] irqs;
  logic h0v = 1'b0, h0rdy;
  fab_req_t h0r = '0;
  int n_errors = 0, n_compared = 0, n_acc = 0, c, k;
  // one config row: inputs, then expected outputs
  typedef struct {
    logic [8:0] mhz; logic [1:0] dw; logic [1:0] fam; logic [7:0] div;
    logic [9:0] rate; logic [5:0] wid; logic err;
  } row_t;
  row_t rows[7] = '{'{20, DW_32, 0, 2, 40, 32, 0},
    '{333, DW_16, 1, 3, 666, 16, 0}, '{200, DW_8, 2, 4, 400, 8, 0},
    '{19, DW_32, 2, 2, 38, 32, 1}, '{334, DW_32, 1, 2, 668, 32, 1},
    '{100, 2'h3, 1, 2, 200, 0, 1}, '{100, DW_16, 1, 0, 200, 16, 1}};
  // 40 MHz system clock
  always #12.5 clk_sys_in = ~clk_sys_in;
  // accepted requests on the axi port
  always @(posedge clk_sys_in) if (ardy === 1'b1) n_acc++;
  fab_initiator_model u_ini (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .send_in(send), .word_in(word), .valid_out(avalid), .req_out(areq),
    .ready_in(ardy));
  fabric_ddr_controller_shell u_dut (.clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in), .ce_in(1'b1), .ext_pll_locked_in(lock_in),
    .mem_family_in(fam_in), .data_width_in(dw_in), .mem_clk_mhz_in(mhz_in),
    .fic_mode_in(mode_in), .clk_div_in(div_in), .axi_req_in(areq),
    .axi_valid_in(avalid), .axi_ready_out(ardy), .ahb0_req_in(h0r),
    .ahb0_valid_in(h0v), .ahb0_ready_out(h0rdy), .ahb1_req_in('0),
    .ahb1_valid_in(1'b0), .ahb1_ready_out(), .mem_req_out(mreq),
    .mem_valid_out(mvalid), .mem_ready_in(mrdy_in), .bus_err_in(berr),
    .cal_start_in(cs), .cal_done_in(cd), .pll_lock_in(pl),
    .ecc_single_in(es), .ecc_double_in(ed), .fabric_if_clk_out(fclk),
    .line_rate_mbps_out(rate), .phy_width_out(wid), .cfg_err_out(cerr),
    .bus_err_irq_out(irqs[4]), .cal_irq_out(irqs[3]),
    .pll_locked_irq_out(irqs[2]), .pll_unlocked_irq_out(irqs[1]),
    .ecc_irq_out(irqs[0]));
  // ************************************************
  // helpers
  // ************************************************
  task tick;
    @(posedge clk_sys_in);
    #1;
  endtask
  task chk(input logic [96:0] g, input logic [96:0] e);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // hand a word to the initiator; optionally wait for acceptance
  task put(input int i, input bit wt);
    word = {1'b1, 32'(i * 8), 64'hA5A5_0000_0000_0000 | 64'(i)};
    send = 1'b1;
    tick;
    send = 1'b0;
    for (k = 0; wt && avalid === 1'b1 && k < 20; k++) tick;
  endtask
  // pulse events low again, then count cycles the chosen irq is high
  task irq(input int b, input int e);
    tick;
    {berr, cs, cd, es, ed} = '0;
    c = 0;
    repeat (5)
    begin
      if (irqs[b] === 1'b1) c++;
      tick;
    end
    chk(c, e);
  endtask
  task end_sim;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog: whole run is a few hundred cycles
  initial
  begin
    #(25 * 20000);
    n_errors++;
    end_sim;
  end
  // ************************************************
  // main sequence
  // ************************************************
  initial
  begin
    repeat (4) tick;
    chk({mvalid, rate, cerr, irqs}, '0);
    repeat (4) tick;
    rst_n_in = 1'b1;
    // configuration table
    foreach (rows[i])
    begin
      {mhz_in, dw_in, div_in} = {rows[i].mhz, rows[i].dw, rows[i].div};
      fam_in = mem_family_t'(rows[i].fam);
      repeat (3) tick;
      chk(rate, rows[i].rate);
      chk(cerr, rows[i].err);
      if (!rows[i].err)
      begin
        chk(wid, rows[i].wid);
        for (k = 0; fclk !== 1'b0 && k < 20; k++) tick;
        for (k = 0; fclk !== 1'b1 && k < 20; k++) tick;
        c = 0;
        do begin tick; c++; end while (fclk === 1'b1 && c < 20);
        while (fclk !== 1'b1 && c < 20) begin tick; c++; end
        chk(c, rows[i].div);
      end
    end
    {mhz_in, dw_in, div_in, fam_in} = {9'h064, DW_32, 8'h02, MEM_DDR3};
    repeat (3) tick;
    // interrupts; cal done alone must stay quiet
    berr = 1'b1; irq(4, 1);
    es = 1'b1; irq(0, 1);
    ed = 1'b1; irq(0, 1);
    cd = 1'b1; irq(3, 0);
    cs = 1'b1; irq(3, 0);
    cd = 1'b1; irq(3, 1);
    pl = 1'b1; irq(2, 1);
    pl = 1'b0; irq(1, 1);
    // lock loss acts as reset
    put(100, 1);
    tick;
    chk(mvalid, 1'b1);
    lock_in = 1'b0;
    repeat (2) tick;
    chk(mvalid, 1'b0);
    c = n_acc;
    put(101, 0);
    repeat (10) tick;
    chk(n_acc, c);
    lock_in = 1'b1;
    for (k = 0; mvalid !== 1'b1 && k < 20; k++) tick;
    chk(mreq, {1'b1, 32'(808), 64'hA5A5_0000_0000_0065});
    mrdy_in = 1'b1;
    tick;
    mrdy_in = 1'b0;
    // fill with memory side stalled: 16 in fifo plus one in the output
    // stage, then one refused
    c = n_acc;
    for (int i = 0; i < 17; i++) put(i, 1);
    put(17, 0);
    repeat (10) tick;
    chk(n_acc - c, 17);
    // drain in order, last word enters once space frees
    mrdy_in = 1'b1;
    for (int i = 0; i < 18; i++)
    begin
      for (k = 0; mvalid !== 1'b1 && k < 20; k++) tick;
      chk(mreq.data, 64'hA5A5_0000_0000_0000 | 64'(i));
      tick;
    end
    repeat (4) tick;
    chk(mvalid, 1'b0);
    // single ahb port: upper data half dropped
    mode_in = FIC_AHB1;
    h0r = {1'b1, 32'h0000_0040, 64'hFFFF_FFFF_1234_5678};
    h0v = 1'b1;
    for (k = 0; h0rdy !== 1'b1 && k < 20; k++) tick;
    h0v = 1'b0;
    chk(h0rdy, 1'b1);
    for (k = 0; mvalid !== 1'b1 && k < 20; k++) tick;
    chk(mreq.data, 64'h0000_0000_1234_5678);
    end_sim;
  end
endmodule
